// >>> logic/input_gearbox_deserializer.v
// Overview of operation
// (R1) each bottom cell has one deserializer, eight parallel bits native
// (R2) modes: seven-bit video, one eight-bit lane, two four-bit lanes
// (R3) video uses word bits 6..0, eight-bit mode bits 7..0
// (R4) dual mode: first cell lane on bits 7..4, third on 3..0
// (R5) three registered stages from serial input to parallel word
// (R6) stage one samples data on both edges of the edge clock
// (R7) stage two aligns words using load strobe and phase select
// (R8) stage three registers the aligned word on the system clock
// (R9) core raises word align request when the boundary must move
// (R10) serial data is taken after the programmable input delay
// (R11) each align request slips one bit; reset clears pipeline, alignment
// (R12) load strobe fires once per complete word of received bits
`timescale 1ns/1ps
`include "gearbox_defs.vh"
module input_gearbox_deserializer (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	input wire gearbox_reset,
	// serial side, delayed pins
	input wire fast_edge_clock,
	input wire first_cell_lane,
	input wire third_cell_lane,
	// core control
	input wire [1:0] mode,
	input wire word_align_request,
	// parallel words to the core
	output wire [`WORD_WIDTH-1:0] parallel_word,
	output wire word_valid,
	input wire word_ready,
	// status
	output reg phase_select,
	output reg overflow
);

// ==========================================
// pin synchronisers
// (R10) delayed lane pins enter here
wire [`SYNC_WIDTH-1:0] pins_sync;

two_flop_sync #(
	.WIDTH(`SYNC_WIDTH)
) pin_sync (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.async_in({fast_edge_clock, first_cell_lane, third_cell_lane}),
	.sync_out(pins_sync)
);

wire edge_clk_s;
wire lane_a_s;
wire lane_c_s;
reg edge_clk_prev;
wire edge_seen;

assign edge_clk_s = pins_sync[2];
assign lane_a_s = pins_sync[1];
assign lane_c_s = pins_sync[0];
// both directions count: the link is double data rate
assign edge_seen = edge_clk_s ^ edge_clk_prev;

// ==========================================
// stage one: edge capture
reg s1_valid;
reg s1_bit_a;
reg s1_bit_c;

// (R6) rising and falling
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		edge_clk_prev <= 1'b0;
		s1_valid <= 1'b0;
		s1_bit_a <= 1'b0;
		s1_bit_c <= 1'b0;
	end
	else if (gearbox_reset)
	begin
		edge_clk_prev <= edge_clk_s;
		s1_valid <= 1'b0;
		s1_bit_a <= 1'b0;
		s1_bit_c <= 1'b0;
	end
	else
	begin
		edge_clk_prev <= edge_clk_s;
		s1_valid <= edge_seen;
		if (edge_seen)
		begin
			s1_bit_a <= lane_a_s;
			s1_bit_c <= lane_c_s;
		end
	end
end

// ==========================================
// control block: word length per mode
reg [2:0] last_bit;

// (R2) mode sets word length
always @*
begin
	case (mode)
		`MODE_VIDEO_BY_SEVEN:
		begin
			last_bit = `VIDEO_LAST_BIT;
		end
		`MODE_BY_EIGHT:
		begin
			last_bit = `EIGHT_LAST_BIT;
		end
		`MODE_DUAL_BY_FOUR:
		begin
			last_bit = `FOUR_LAST_BIT;
		end
		default:
		begin
			// code three is unused; treated as eight-bit
			last_bit = `EIGHT_LAST_BIT;
		end
	endcase
end

// ==========================================
// stage two: shift and align
reg [6:0] shift_a;
reg [2:0] shift_c;
reg [2:0] bit_count;
reg slip_pending;
reg [1:0] mode_prev;
reg s2_valid;
reg [`WORD_WIDTH-1:0] s2_word;
reg [`WORD_WIDTH-1:0] next_word;
wire load_strobe;
wire mode_changed;

// a partial word is abandoned when the mode moves
assign mode_changed = (mode != mode_prev);
// (R12) strobe on the last bit
// no strobe while the mode moves, so no mixed-width word escapes
assign load_strobe = s1_valid && !slip_pending && !mode_changed &&
	(bit_count == last_bit);

// (R1) (R3) (R4) output layout
always @*
begin
	case (mode)
		`MODE_VIDEO_BY_SEVEN:
		begin
			next_word = {1'b0, shift_a[5:0], s1_bit_a};
		end
		`MODE_DUAL_BY_FOUR:
		begin
			next_word = {shift_a[2:0], s1_bit_a, shift_c[2:0], s1_bit_c};
		end
		`MODE_BY_EIGHT:
		begin
			next_word = {shift_a[6:0], s1_bit_a};
		end
		default:
		begin
			next_word = {shift_a[6:0], s1_bit_a};
		end
	endcase
end

// (R7) (R11) slip one bit
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		shift_a <= `SHIFT_ZERO;
		shift_c <= 3'h0;
		bit_count <= `BIT_COUNT_ZERO;
		slip_pending <= 1'b0;
		phase_select <= 1'b0;
		mode_prev <= `MODE_VIDEO_BY_SEVEN;
		s2_valid <= 1'b0;
		s2_word <= `WORD_ZERO;
	end
	else if (gearbox_reset)
	begin
		shift_a <= `SHIFT_ZERO;
		shift_c <= 3'h0;
		bit_count <= `BIT_COUNT_ZERO;
		slip_pending <= 1'b0;
		phase_select <= 1'b0;
		mode_prev <= mode;
		s2_valid <= 1'b0;
		s2_word <= `WORD_ZERO;
	end
	else
	begin
		mode_prev <= mode;
		s2_valid <= load_strobe;
		if (load_strobe)
		begin
			s2_word <= next_word;
		end
		// a mode change restarts the word so no mixed-width word escapes
		if (mode_changed)
		begin
			bit_count <= `BIT_COUNT_ZERO;
		end
		else if (s1_valid && slip_pending)
		begin
			// dropped bit moves the boundary; sampling phase flips
			slip_pending <= 1'b0;
			phase_select <= ~phase_select;
		end
		else if (s1_valid)
		begin
			shift_a <= {shift_a[5:0], s1_bit_a};
			shift_c <= {shift_c[1:0], s1_bit_c};
			if (bit_count == last_bit)
			begin
				bit_count <= `BIT_COUNT_ZERO;
			end
			else
			begin
				bit_count <= bit_count + `BIT_COUNT_ONE;
			end
		end
		// (R9) request taken; the set wins over the consuming clear
		if (word_align_request)
		begin
			slip_pending <= 1'b1;
		end
	end
end

// ==========================================
// stage three: hand-off register
reg s3_valid;
reg [`WORD_WIDTH-1:0] s3_word;
wire fifo_in_ready;

// (R5) (R8) third register
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		s3_valid <= 1'b0;
		s3_word <= `WORD_ZERO;
	end
	else if (gearbox_reset)
	begin
		s3_valid <= 1'b0;
		s3_word <= `WORD_ZERO;
	end
	else
	begin
		if (s2_valid)
		begin
			s3_valid <= 1'b1;
			s3_word <= s2_word;
		end
		else if (fifo_in_ready)
		begin
			s3_valid <= 1'b0;
		end
	end
end

// (R8) loss stays flagged
always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		overflow <= 1'b0;
	end
	else if (gearbox_reset)
	begin
		overflow <= 1'b0;
	end
	// the link cannot be paused, so a stalled word is lost
	else if (s2_valid && s3_valid && !fifo_in_ready)
	begin
		overflow <= 1'b1;
	end
end

// ==========================================
// buffering toward the core
word_fifo #(
	.WIDTH(`WORD_WIDTH),
	.DEPTH(`FIFO_DEPTH),
	.ADDR_WIDTH(`FIFO_ADDR_WIDTH)
) out_fifo (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.flush(gearbox_reset),
	.in_valid(s3_valid),
	.in_ready(fifo_in_ready),
	.in_data(s3_word),
	.out_valid(word_valid),
	.out_ready(word_ready),
	.out_data(parallel_word)
);

endmodule // input_gearbox_deserializer

// >>> logic/gearbox_defs.vh
`ifndef GEARBOX_DEFS_VH
`define GEARBOX_DEFS_VH

// ==========================================
// operating modes
`define MODE_VIDEO_BY_SEVEN 2'h0
`define MODE_BY_EIGHT 2'h1
`define MODE_DUAL_BY_FOUR 2'h2

// ==========================================
// word widths, output layout
`define WORD_WIDTH 8
`define LANE_WIDTH 4
`define VIDEO_LAST_BIT 3'h6
`define EIGHT_LAST_BIT 3'h7
`define FOUR_LAST_BIT 3'h3
`define BIT_COUNT_ZERO 3'h0
`define BIT_COUNT_ONE 3'h1

// ==========================================
// fifo and synchroniser
`define FIFO_DEPTH 32
`define FIFO_ADDR_WIDTH 5
`define SYNC_WIDTH 3

// ==========================================
// reset values
`define WORD_ZERO 8'h00
`define LANE_ZERO 4'h0
`define SHIFT_ZERO 7'h00

`endif

// >>> logic/two_flop_sync.v
`timescale 1ns/1ps
module two_flop_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// asynchronous levels in, synchronised out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

// ==========================================
// two flops, first one read only by the second
reg [WIDTH-1:0] meta;

always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		meta <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end
	else
	begin
		meta <= async_in;
		sync_out <= meta;
	end
end

endmodule // two_flop_sync

// >>> logic/word_fifo.v
`timescale 1ns/1ps
module word_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter ADDR_WIDTH = 5
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	input wire flush,
	// filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// draining side, registered
	output reg out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);

// ==========================================
// storage
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [ADDR_WIDTH-1:0] wr_ptr;
reg [ADDR_WIDTH-1:0] rd_ptr;
reg [ADDR_WIDTH:0] count;
wire push;
wire pop;

// full only when every slot holds a word
assign in_ready = (count != DEPTH[ADDR_WIDTH:0]);
assign push = in_valid && in_ready;
// refill the output register whenever it is empty or being taken
assign pop = (count != {(ADDR_WIDTH+1){1'b0}}) && (!out_valid || out_ready);

always @(posedge sys_clk)
begin
	if (push)
		mem[wr_ptr] <= in_data;
end

always @(posedge sys_clk or negedge reset_n)
begin
	if (!reset_n)
	begin
		wr_ptr <= {ADDR_WIDTH{1'b0}};
		rd_ptr <= {ADDR_WIDTH{1'b0}};
		count <= {(ADDR_WIDTH+1){1'b0}};
		out_valid <= 1'b0;
		out_data <= {WIDTH{1'b0}};
	end
	else if (flush)
	begin
		wr_ptr <= {ADDR_WIDTH{1'b0}};
		rd_ptr <= {ADDR_WIDTH{1'b0}};
		count <= {(ADDR_WIDTH+1){1'b0}};
		out_valid <= 1'b0;
		out_data <= {WIDTH{1'b0}};
	end
	else
	begin
		if (push)
			wr_ptr <= wr_ptr + 1'b1;
		if (pop)
		begin
			rd_ptr <= rd_ptr + 1'b1;
			out_data <= mem[rd_ptr];
			out_valid <= 1'b1;
		end
		else if (out_ready)
			out_valid <= 1'b0;
		if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end
end

endmodule // word_fifo

// >>> testbench/gearbox_monitor.sv
`timescale 1ns/1ps
// ==========
// port checker
module gearbox_monitor (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	input wire gearbox_reset,
	// link and control
	input wire fast_edge_clock,
	input wire [1:0] mode,
	input wire word_align_request,
	// core side
	input wire [7:0] parallel_word,
	input wire word_valid,
	input wire word_ready,
	input wire phase_select,
	input wire overflow
);
	reg [5:0] req_age;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n || gearbox_reset);
	// saturating age, so a stale request never excuses a slip
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			req_age <= 6'h3f;
		else if (word_align_request)
			req_age <= 6'h00;
		else if (req_age != 6'h3f)
			req_age <= req_age + 6'h01;
	end
	// ==========
	// assertions
	// word held
	chk_word_holds: assert property (word_valid && !word_ready &&
		!gearbox_reset |=>
		word_valid && $stable(parallel_word)) else $error("word dropped");
	chk_video_top: assert property (word_valid && mode == 2'h0 |->
		!parallel_word[7]) else $error("video bit seven set");
	chk_slip_cause: assert property ($changed(phase_select) &&
		!$past(gearbox_reset) |-> req_age < 6'h28)
		else $error("slip without request");
	chk_slip_spacing: assert property ($changed(phase_select) |=>
		$stable(phase_select) [*3]) else $error("slips too close");
	chk_loss_sticky: assert property (overflow && !gearbox_reset |=>
		overflow) else $error("overflow cleared");
	chk_loss_blocked: assert property ($rose(overflow) |->
		$past(word_valid)) else $error("loss while not full");
	chk_reset_clears: assert property (disable iff (!reset_n)
		gearbox_reset |=> !word_valid && !overflow && !phase_select)
		else $error("reset left state");
	chk_start_quiet: assert property ($rose(reset_n) |->
		!word_valid && !overflow && !phase_select)
		else $error("outputs set after reset");
	cover property ($rose(overflow));
	cover property ($changed(phase_select));
	cover property (word_valid && word_ready && mode == 2'h2);
endmodule // gearbox_monitor
bind input_gearbox_deserializer gearbox_monitor mon_u (.sys_clk(sys_clk),
	.reset_n(reset_n), .gearbox_reset(gearbox_reset),
	.fast_edge_clock(fast_edge_clock), .mode(mode),
	.word_align_request(word_align_request), .parallel_word(parallel_word),
	.word_valid(word_valid), .word_ready(word_ready),
	.phase_select(phase_select), .overflow(overflow));

// >>> testbench/serial_source.sv
`timescale 1ns/1ps
// ==========
// serial transmitter, msb first
module serial_source (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// frame request
	input wire start,
	input wire [4:0] nbits,
	input wire [15:0] bits_a,
	input wire [15:0] bits_c,
	output reg busy,
	// link pins
	output reg link_clk,
	output reg lane_a,
	output reg lane_c
);
	reg [4:0] left;
	reg [1:0] ph;
	reg [15:0] sa;
	reg [15:0] sc;
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy <= 1'b0;
			link_clk <= 1'b0;
			lane_a <= 1'b0;
			lane_c <= 1'b0;
			ph <= 2'h0;
		end
		else if (!busy && start)
		begin
			sa <= bits_a << (5'h10 - nbits);
			sc <= bits_c << (5'h10 - nbits);
			left <= nbits;
			busy <= 1'b1;
			ph <= 2'h0;
		end
		else
		begin
			ph <= ph + 2'h1;
			// idle lines wander, clock stands still
			if (ph == 2'h1)
			begin
				lane_a <= busy ? sa[15] : ~lane_a;
				lane_c <= busy ? sc[15] : ~lane_c;
				sa <= sa << 1;
				sc <= sc << 1;
			end
			if (busy && ph == 2'h3)
			begin
				link_clk <= ~link_clk;
				left <= left - 5'h01;
				busy <= left != 5'h01;
			end
		end
	end
endmodule // serial_source

// >>> testbench/input_gearbox_deserializer_tb.sv
`timescale 1ns/1ps
module input_gearbox_deserializer_tb;
	reg sys_clk = 1'b0;
	reg reset_n = 1'b0;
	reg gearbox_reset = 1'b0;
	reg [1:0] mode = 2'h1;
	reg word_align_request = 1'b0;
	reg word_ready = 1'b0;
	reg start = 1'b0;
	reg [4:0] nbits = 5'h08;
	reg [15:0] bits_a = 16'h0000;
	reg [15:0] bits_c = 16'h0000;
	wire busy, link_clk, lane_a, lane_c, word_valid, phase_select, overflow;
	wire [7:0] parallel_word;
	integer mismatches = 0;
	integer checked = 0;
	integer cycles = 0;
	integer i;
	reg p;
	always #12.5 sys_clk = ~sys_clk;
	serial_source src_u (.sys_clk(sys_clk), .reset_n(reset_n), .start(start),
		.nbits(nbits), .bits_a(bits_a), .bits_c(bits_c), .busy(busy),
		.link_clk(link_clk), .lane_a(lane_a), .lane_c(lane_c));
	input_gearbox_deserializer dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
		.gearbox_reset(gearbox_reset), .fast_edge_clock(link_clk),
		.first_cell_lane(lane_a), .third_cell_lane(lane_c), .mode(mode),
		.word_align_request(word_align_request),
		.parallel_word(parallel_word), .word_valid(word_valid),
		.word_ready(word_ready), .phase_select(phase_select),
		.overflow(overflow));
	// ==========
	// shared tasks
	task check(input [7:0] got, input [7:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task test_done;
	begin
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task send(input [4:0] n, input [15:0] a, input [15:0] c);
	begin
		@(posedge sys_clk);
		nbits <= n;
		bits_a <= a;
		bits_c <= c;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(negedge sys_clk);
		while (busy)
			@(negedge sys_clk);
	end
	endtask
	task take(input [7:0] exp);
		integer n;
	begin
		n = 0;
		while (word_valid !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk);
			n = n + 1;
		end
		check({7'h00, word_valid}, 8'h01);
		check(parallel_word, exp);
		@(posedge sys_clk);
		word_ready <= 1'b1;
		@(posedge sys_clk);
		word_ready <= 1'b0;
		@(negedge sys_clk);
	end
	endtask
	// ==========
	// scenarios
	initial
	begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(negedge sys_clk);
		// eight-bit words back to back
		send(5'h08, 16'h00a5, 16'h0000);
		send(5'h08, 16'h003c, 16'h0000);
		take(8'ha5);
		take(8'h3c);
		@(posedge sys_clk);
		mode <= 2'h0;
		send(5'h07, 16'h005b, 16'h0000);
		take(8'h5b);
		// partial word dropped on mode change
		@(posedge sys_clk);
		mode <= 2'h1;
		send(5'h03, 16'h0007, 16'h0000);
		repeat (8) @(posedge sys_clk);
		mode <= 2'h2;
		send(5'h04, 16'h0009, 16'h0006);
		take(8'h96);
		@(posedge sys_clk);
		mode <= 2'h1;
		p = phase_select;
		@(posedge sys_clk);
		word_align_request <= 1'b1;
		@(posedge sys_clk);
		word_align_request <= 1'b0;
		send(5'h09, 16'h012d, 16'h0000);
		take(8'h2d);
		check({7'h00, phase_select}, {7'h00, ~p});
		// fill past depth with core stalled
		for (i = 0; i < 40; i = i + 1)
			send(5'h08, i[15:0], 16'h0000);
		repeat (16) @(negedge sys_clk);
		check({7'h00, overflow}, 8'h01);
		for (i = 0; i < 32; i = i + 1)
			take(i[7:0]);
		@(posedge sys_clk);
		gearbox_reset <= 1'b1;
		@(posedge sys_clk);
		gearbox_reset <= 1'b0;
		@(negedge sys_clk);
		check({6'h00, overflow, word_valid}, 8'h00);
		test_done;
	end
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
endmodule // input_gearbox_deserializer_tb
